// *** logic/status_output_pkg.sv ***
// constants shared by the status output selector
package status_output_pkg;

	////////////////////////////////////////////////////////////////////////
	// bus map (byte addresses)
	localparam int ADDR_WIDTH = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SEL_BASE = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam int OUTPUT_COUNT = 5;

	////////////////////////////////////////////////////////////////////////
	// control register fields
	localparam int CTRL_RELAY_MODE_BIT = 0;
	localparam int CTRL_OPSRC_LSB = 1;
	localparam int OPSRC_WIDTH = 2;
	localparam int CTRL_ZERO_HZ_BIT = 3;
	localparam int CTRL_OL_CURRENT_BIT = 4;
	localparam int CTRL_UDO_BIT = 5;
	localparam logic [1:0] OPSRC_KEYPAD = 2'h0;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic RELAY_MODE_RESET = 1'h0;
	localparam logic [1:0] OPSRC_RESET = 2'h0;
	localparam logic ZERO_HZ_RESET = 1'h0;
	localparam logic OL_CURRENT_RESET = 1'h0;
	localparam logic UDO_RESET = 1'h0;
	localparam logic [4:0][4:0] SEL_RESET =
		{5'h08, 5'h05, 5'h02, 5'h01, 5'h00};

	////////////////////////////////////////////////////////////////////////
	// status register fields
	localparam int STAT_OUT_LSB = 0;
	localparam int STAT_MAKE_BIT = 5;
	localparam int STAT_BREAK_BIT = 6;
	localparam int STAT_READY_BIT = 7;
	localparam int STAT_RUN_BIT = 8;
	localparam int STAT_STOP_BIT = 9;
	localparam int STAT_UV_BIT = 10;
	localparam int STAT_IPF_BIT = 11;
	localparam int STAT_OL_BIT = 12;
	localparam int STAT_KP_BIT = 13;
	localparam int STAT_ECHO_BIT = 14;
	localparam int STAT_EST_BIT = 15;

	////////////////////////////////////////////////////////////////////////
	// selection codes
	localparam int SEL_RUNNING = 0;
	localparam int SEL_FREQ_ARRIVAL = 1;
	localparam int SEL_FREQ_LEVEL = 2;
	localparam int SEL_UNDERVOLTAGE = 3;
	localparam int SEL_RESTART = 4;
	localparam int SEL_OVERLOAD = 5;
	localparam int SEL_KEYPAD = 6;
	localparam int SEL_STOPPING = 7;
	localparam int SEL_READY = 8;
	localparam int SEL_ECHO = 9;
	localparam int SEL_ALARM_W1 = 10;
	localparam int SEL_FAN = 14;
	localparam int SEL_RETRY = 15;
	localparam int SEL_UNIVERSAL = 16;
	localparam int SEL_OVERHEAT = 17;
	localparam int SEL_MOTOR_ERR = 18;
	localparam int SEL_CHANGEOVER = 19;
	localparam int SEL_MOTOR1 = 20;
	localparam int SEL_MOTOR_NUM_W1 = 25;
	localparam int SEL_COUNT = 28;
	localparam int MOTOR_COUNT = 5;

	////////////////////////////////////////////////////////////////////////
	// levels and timing
	localparam logic [9:0] UV_LEVEL_VOLTS = 10'h0C8;
	localparam int CLK_HZ = 100000000;
	localparam int POWERUP_TIME_S = 1;
	localparam int POWERUP_CYCLES = POWERUP_TIME_S * CLK_HZ;
	localparam int POWERUP_CNT_WIDTH = 27;

endpackage

// *** logic/status_output_selector.sv ***
// status output selector: fault relay, five routed terminals, status flags
// What this block does
// - relay mode 0: make open, break closed normally; reversed on fault.
// - relay mode 1: make closed, break open normally; reversed on fault.
// - relay mode 1: make stays open until control voltage established.
// - five terminals, each with its own selection setting.
// - codes 0-9 route running through command echo in documented order.
// - codes 10-13 alarm bits; 14-17 fan, retry, universal, overheat.
// - code 18 motor select error; code 19 changeover in progress.
// - codes 20-24 route motor 1 to 5 selected indications.
// - codes 25-27 route motor number bits of weight 1, 2, 4.
// - running while producing frequency, off during DC injection braking.
// - undervoltage while DC bus below 200 V, released above it.
// - restart flag from pull-in until frequency regained; never at 0 Hz.
// - overload warning per selected motor, thermal or current based.
// - keypad flag whenever operation source setting is zero.
// - stopping is the inverse of running.
// - ready when powers good, no protection active, after power-up time.
// - echo set by run command; stop clears after output stops, trip now.
`timescale 1ns/1ps
`default_nettype none

module status_output_selector
#(
	parameter int POWERUP_CYCLES = status_output_pkg::POWERUP_CYCLES
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// drive state
	input wire logic freq_output_active_i,
	input wire logic dc_brake_active_i,
	input wire logic [9:0] dc_bus_volts_i,
	input wire logic main_power_ok_i,
	input wire logic control_power_ok_i,
	input wire logic protect_active_i,
	// momentary power failure restart
	input wire logic restart_pullin_start_i,
	input wire logic restart_freq_regained_i,
	// overload warning sources, one bit per motor
	input wire logic [4:0] thermal_warn_i,
	input wire logic [4:0] current_warn_i,
	// operation commands
	input wire logic fwd_cmd_i,
	input wire logic rev_cmd_i,
	input wire logic stop_cmd_i,
	input wire logic coast_cmd_i,
	// flags produced elsewhere
	input wire logic freq_arrival_flag_i,
	input wire logic freq_level_flag_i,
	input wire logic [3:0] alarm_code_i,
	input wire logic fan_running_i,
	input wire logic retry_active_i,
	input wire logic overheat_warning_flag_i,
	input wire logic motor_select_error_flag_i,
	input wire logic motor_changeover_flag_i,
	input wire logic [2:0] motor_number_i,
	// fault relay contacts
	output logic relay_make_contact_o,
	output logic relay_break_contact_o,
	// routed terminals
	output logic status_output_1_o,
	output logic status_output_2_o,
	output logic status_output_3_o,
	output logic status_output_4_o,
	output logic status_output_5_o
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic relay_mode;
		logic [1:0] opsrc;
		logic zero_hz;
		logic ol_current;
		logic udo;
		logic [4:0][4:0] sel;
		logic [26:0] powerup_cnt;
		logic established;
		logic ready;
		logic running;
		logic undervoltage;
		logic restart;
		logic overload;
		logic echo;
		logic stop_pending;
		logic [4:0] outs;
		logic make;
		logic brk;
	} state_type;

	state_type state_reg;
	state_type state_next;

	logic [27:0] source;
	logic [4:0] routed;
	logic [4:0] motor_onehot;
	logic [7:0] byte_index;
	logic access;
	logic wr_low;

	////////////////////////////////////////////////////////////////////////
	// signal sources and the five routers

	always_comb
	begin
		motor_onehot = 5'h00;
		for (int m = 0; m < status_output_pkg::MOTOR_COUNT; m++)
		begin
			if (int'(motor_number_i) == m + 1)
			begin
				motor_onehot[m] = 1'b1;
			end
		end
	end

	always_comb
	begin
		source = 28'h0000000;
		source[status_output_pkg::SEL_RUNNING] = state_reg.running;
		source[status_output_pkg::SEL_FREQ_ARRIVAL] = freq_arrival_flag_i;
		source[status_output_pkg::SEL_FREQ_LEVEL] = freq_level_flag_i;
		source[status_output_pkg::SEL_UNDERVOLTAGE] = state_reg.undervoltage;
		source[status_output_pkg::SEL_RESTART] = state_reg.restart;
		source[status_output_pkg::SEL_OVERLOAD] = state_reg.overload;
		source[status_output_pkg::SEL_KEYPAD] =
			(state_reg.opsrc == status_output_pkg::OPSRC_KEYPAD);
		source[status_output_pkg::SEL_STOPPING] = ~state_reg.running;
		source[status_output_pkg::SEL_READY] = state_reg.ready;
		source[status_output_pkg::SEL_ECHO] = state_reg.echo;
		source[status_output_pkg::SEL_ALARM_W1 +: 4] = alarm_code_i;
		source[status_output_pkg::SEL_FAN] = fan_running_i;
		source[status_output_pkg::SEL_RETRY] = retry_active_i;
		source[status_output_pkg::SEL_UNIVERSAL] = state_reg.udo;
		source[status_output_pkg::SEL_OVERHEAT] = overheat_warning_flag_i;
		source[status_output_pkg::SEL_MOTOR_ERR] =
			motor_select_error_flag_i;
		source[status_output_pkg::SEL_CHANGEOVER] =
			motor_changeover_flag_i;
		source[status_output_pkg::SEL_MOTOR1 +: 5] = motor_onehot;
		// motor number passes straight through as binary
		source[status_output_pkg::SEL_MOTOR_NUM_W1 +: 3] = motor_number_i;
	end

	// each terminal has its own selection setting
	for (genvar i = 0; i < status_output_pkg::OUTPUT_COUNT; i++)
	begin : g_route
		status_signal_mux u_mux
		(
			.source_i(source),
			.code_i(state_reg.sel[i]),
			.selected_o(routed[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// bus decode

	assign access = wb_cyc_i & wb_stb_i & ~state_reg.ack;
	// every writable field sits in the low byte, so only lane 0 carries writes
	assign wr_low = access & wb_we_i & wb_sel_i[0];
	assign byte_index = wb_adr_i;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		logic powered;
		logic [31:0] rd;
		logic warn_src;
		powered = 1'b0;
		rd = 32'h00000000;
		warn_src = 1'b0;
		state_next = state_reg;

		// classic single cycle: one wait state, ack for one cycle
		state_next.ack = access;
		if (access & ~wb_we_i)
		begin
			if (byte_index == status_output_pkg::ADDR_CTRL)
			begin
				rd[status_output_pkg::CTRL_RELAY_MODE_BIT] = state_reg.relay_mode;
				rd[status_output_pkg::CTRL_OPSRC_LSB +: 2] = state_reg.opsrc;
				rd[status_output_pkg::CTRL_ZERO_HZ_BIT] = state_reg.zero_hz;
				rd[status_output_pkg::CTRL_OL_CURRENT_BIT] = state_reg.ol_current;
				rd[status_output_pkg::CTRL_UDO_BIT] = state_reg.udo;
			end
			for (int i = 0; i < status_output_pkg::OUTPUT_COUNT; i++)
			begin
				if (byte_index == status_output_pkg::ADDR_SEL_BASE + 8'(4 * i))
				begin
					rd[4:0] = state_reg.sel[i];
				end
			end
			if (byte_index == status_output_pkg::ADDR_STATUS)
			begin
				rd[status_output_pkg::STAT_OUT_LSB +: 5] = state_reg.outs;
				rd[status_output_pkg::STAT_MAKE_BIT] = state_reg.make;
				rd[status_output_pkg::STAT_BREAK_BIT] = state_reg.brk;
				rd[status_output_pkg::STAT_READY_BIT] = state_reg.ready;
				rd[status_output_pkg::STAT_RUN_BIT] = state_reg.running;
				rd[status_output_pkg::STAT_STOP_BIT] = ~state_reg.running;
				rd[status_output_pkg::STAT_UV_BIT] = state_reg.undervoltage;
				rd[status_output_pkg::STAT_IPF_BIT] = state_reg.restart;
				rd[status_output_pkg::STAT_OL_BIT] = state_reg.overload;
				rd[status_output_pkg::STAT_KP_BIT] =
					(state_reg.opsrc == status_output_pkg::OPSRC_KEYPAD);
				rd[status_output_pkg::STAT_ECHO_BIT] = state_reg.echo;
				rd[status_output_pkg::STAT_EST_BIT] = state_reg.established;
			end
		end
		// unmapped reads answer zero; writes there are dropped
		state_next.rdata = rd;

		if (wr_low & (byte_index == status_output_pkg::ADDR_CTRL))
		begin
			state_next.relay_mode =
				wb_dat_i[status_output_pkg::CTRL_RELAY_MODE_BIT];
			state_next.opsrc = wb_dat_i[status_output_pkg::CTRL_OPSRC_LSB +: 2];
			state_next.zero_hz = wb_dat_i[status_output_pkg::CTRL_ZERO_HZ_BIT];
			state_next.ol_current =
				wb_dat_i[status_output_pkg::CTRL_OL_CURRENT_BIT];
			state_next.udo = wb_dat_i[status_output_pkg::CTRL_UDO_BIT];
		end
		for (int i = 0; i < status_output_pkg::OUTPUT_COUNT; i++)
		begin
			if (wr_low &
				(byte_index == status_output_pkg::ADDR_SEL_BASE + 8'(4 * i)))
			begin
				state_next.sel[i] = wb_dat_i[4:0];
			end
		end

		// control voltage comes up a fixed time after reset
		if (!state_reg.established)
		begin
			if (int'(state_reg.powerup_cnt) >= POWERUP_CYCLES - 1)
			begin
				state_next.established = 1'b1;
			end
			else
			begin
				state_next.powerup_cnt = state_reg.powerup_cnt + 27'h0000001;
			end
		end

		powered = state_reg.established & main_power_ok_i & control_power_ok_i;
		state_next.ready = powered & ~protect_active_i;

		// braking holds running off even with frequency present
		state_next.running = freq_output_active_i & ~dc_brake_active_i;

		state_next.undervoltage =
			(dc_bus_volts_i < status_output_pkg::UV_LEVEL_VOLTS);

		// set wins over a simultaneous regain; 0 Hz restart suppresses
		if (state_reg.zero_hz)
		begin
			state_next.restart = 1'b0;
		end
		else if (restart_pullin_start_i)
		begin
			state_next.restart = 1'b1;
		end
		else if (restart_freq_regained_i)
		begin
			state_next.restart = 1'b0;
		end

		// unselected or invalid motor number gives no warning
		for (int m = 0; m < status_output_pkg::MOTOR_COUNT; m++)
		begin
			if (motor_onehot[m])
			begin
				warn_src = state_reg.ol_current ?
					current_warn_i[m] : thermal_warn_i[m];
			end
		end
		state_next.overload = warn_src;

		// protective clears win: a trip must not leave the echo standing
		if (coast_cmd_i | protect_active_i)
		begin
			state_next.echo = 1'b0;
			state_next.stop_pending = 1'b0;
		end
		else if (fwd_cmd_i | rev_cmd_i)
		begin
			state_next.echo = 1'b1;
			state_next.stop_pending = 1'b0;
		end
		else if (stop_cmd_i & state_reg.echo)
		begin
			state_next.stop_pending = 1'b1;
		end
		if (state_reg.stop_pending & ~freq_output_active_i &
			~(fwd_cmd_i | rev_cmd_i | coast_cmd_i | protect_active_i))
		begin
			// released only once output frequency has gone
			state_next.echo = 1'b0;
			state_next.stop_pending = 1'b0;
		end

		state_next.outs = routed;

		// fault relay; break is always the complement of make
		// mode 1 stays de-energised until control voltage is up
		state_next.make = state_reg.relay_mode ?
			(~protect_active_i & state_reg.established) :
			protect_active_i;
		state_next.brk = ~state_next.make;
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= '0;
			state_reg.relay_mode <= status_output_pkg::RELAY_MODE_RESET;
			state_reg.opsrc <= status_output_pkg::OPSRC_RESET;
			state_reg.zero_hz <= status_output_pkg::ZERO_HZ_RESET;
			state_reg.ol_current <= status_output_pkg::OL_CURRENT_RESET;
			state_reg.udo <= status_output_pkg::UDO_RESET;
			state_reg.sel <= status_output_pkg::SEL_RESET;
			// relay at rest: break closed
			state_reg.brk <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign wb_ack_o = state_reg.ack;
	assign wb_dat_o = state_reg.rdata;
	assign relay_make_contact_o = state_reg.make;
	assign relay_break_contact_o = state_reg.brk;
	assign status_output_1_o = state_reg.outs[0];
	assign status_output_2_o = state_reg.outs[1];
	assign status_output_3_o = state_reg.outs[2];
	assign status_output_4_o = state_reg.outs[3];
	assign status_output_5_o = state_reg.outs[4];

endmodule

`default_nettype wire

// *** logic/status_signal_mux.sv ***
// one selectable status terminal: code to signal routing
`timescale 1ns/1ps
`default_nettype none

module status_signal_mux
(
	// candidate signals, indexed by selection code
	input wire logic [27:0] source_i,
	// selection setting
	input wire logic [4:0] code_i,
	// routed signal
	output logic selected_o
);

	always_comb
	begin
		// codes 28..31 have no source and stay off
		if (int'(code_i) < status_output_pkg::SEL_COUNT)
		begin
			selected_o = source_i[code_i];
		end
		else
		begin
			selected_o = 1'b0;
		end
	end

endmodule

`default_nettype wire

// *** verif/host_terminal_reader.sv ***
// host controller model that latches the output terminals on request
`timescale 1ns/1ps
`default_nettype none
module host_terminal_reader
(
	input wire logic clk_i,
	input wire logic read_i,
	input wire logic [6:0] pins_i,
	output logic [6:0] pins_o,
	output logic valid_o
);
	always_ff @(posedge clk_i)
	begin
		valid_o <= read_i;
		// a stale sample is not kept between reads
		pins_o <= read_i ? pins_i : ~pins_o;
	end
endmodule
`default_nettype wire

// *** verif/status_output_selector_props.sv ***
// checker bound to the status output selector
`timescale 1ns/1ps
`default_nettype none
module status_output_selector_props
#(
	parameter int POWERUP_CYCLES = 20
)
(
	input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic protect_active_i, relay_make_contact_o,
	input wire logic relay_break_contact_o, status_output_1_o,
	input wire logic status_output_2_o, status_output_3_o,
	input wire logic status_output_4_o, status_output_5_o,
	input wire logic freq_arrival_flag_i, freq_level_flag_i, fan_running_i,
	input wire logic retry_active_i, overheat_warning_flag_i,
	input wire logic motor_select_error_flag_i, motor_changeover_flag_i,
	input wire logic [3:0] alarm_code_i,
	input wire logic [2:0] motor_number_i
);
	// codes fed straight from an input, plus the unused codes
	localparam logic [31:0] DIRECT = 32'hFE0EFC06;
	int cnt;
	logic mode, quiet, wr;
	logic [4:0][4:0] sel;
	logic [31:0] src, src_q;
	logic [4:0] outs;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	assign outs = {status_output_5_o, status_output_4_o, status_output_3_o,
		status_output_2_o, status_output_1_o};
	assign src = {4'h0, motor_number_i, 5'h00, motor_changeover_flag_i,
		motor_select_error_flag_i, overheat_warning_flag_i, 1'h0,
		retry_active_i, fan_running_i, alarm_code_i, 7'h00,
		freq_level_flag_i, freq_arrival_flag_i, 1'h0};
	// copies trail the design by one edge, so judge only on an idle bus
	assign quiet = !wb_cyc_i && cnt > 3;
	assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
	always_ff @(posedge clk_i)
	begin
		src_q <= src;
		if (rst_i)
		begin
			cnt <= 0;
			mode <= 1'h0;
			sel <= status_output_pkg::SEL_RESET;
		end
		else
		begin
			cnt <= (cnt < 100000) ? cnt + 1 : cnt;
			if (wr && wb_adr_i == 8'h00)
				mode <= wb_dat_i[0];
			if (wr && wb_adr_i[7:5] == 3'h0 && wb_adr_i[1:0] == 2'h0 &&
				wb_adr_i[4:2] inside {[3'h1:3'h5]})
				sel[wb_adr_i[4:2] - 3'h1] <= wb_dat_i[4:0];
		end
	end
	////////////////////////////////////////
	AST_BREAK_INV: assert property (
		relay_break_contact_o == !relay_make_contact_o)
		else $error("break contact is not the inverse of make");
	AST_MODE0: assert property (
		!mode && !wb_cyc_i |=> relay_make_contact_o == $past(protect_active_i))
		else $error("mode 0 make contact does not follow the fault");
	AST_MODE1_FAULT: assert property (
		mode && protect_active_i && !wb_cyc_i |=> !relay_make_contact_o)
		else $error("mode 1 make contact closed during fault");
	AST_MODE1_CLOSED: assert property (
		mode && !protect_active_i && !wb_cyc_i && cnt > POWERUP_CYCLES + 2
		|=> relay_make_contact_o)
		else $error("mode 1 make contact open in normal state");
	AST_EARLY_OPEN: assert property (
		mode && !wb_cyc_i && cnt < POWERUP_CYCLES |-> !relay_make_contact_o)
		else $error("make contact closed before power-up");
	AST_ACK_ONE: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	AST_ACK_PULSE: assert property ($rose(wb_ack_o) |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	for (genvar i = 0; i < 5; i++)
	begin : g_route
		AST_ROUTE: assert property (
			quiet && $past(quiet) && DIRECT[sel[i]] |->
			outs[i] == src_q[sel[i]])
			else $error("terminal does not follow its selected source");
	end
	cover property (mode && protect_active_i);
	cover property ($rose(wb_ack_o) && wb_we_i);
	cover property (quiet && sel[0] > 5'h1B);
	cover property (mode && relay_make_contact_o);
endmodule

bind status_output_selector status_output_selector_props
	#(.POWERUP_CYCLES(POWERUP_CYCLES)) props
(
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .protect_active_i, .relay_make_contact_o,
	.relay_break_contact_o, .status_output_1_o, .status_output_2_o,
	.status_output_3_o, .status_output_4_o, .status_output_5_o,
	.freq_arrival_flag_i, .freq_level_flag_i, .fan_running_i,
	.retry_active_i, .overheat_warning_flag_i, .motor_select_error_flag_i,
	.motor_changeover_flag_i, .alarm_code_i, .motor_number_i
);
`default_nettype wire

// *** verif/tb_status_output_selector.sv ***
// self-checking bench for the status output selector
`timescale 1ns/1ps
`default_nettype none
module tb_status_output_selector;
	localparam int PWR = 200;
	logic clk_i = '0, rst_i = '1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0;
	logic [7:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = '0;
	logic [31:0] wb_dat_i = '0, wb_dat_o, r = 32'hB41C0C80;
	logic wb_ack_o, rd = '0, pv, echo = '0, power_fail_restart_flag = '0, est = '0;
	logic freq = '0, brake = '0, m_ok = '1, c_ok = '1, prot = '0;
	logic freq_arrival_flag = '0, fdt = '0, fan = '0, retry = '0, oh = '0, err = '0;
	logic chg = '0;
	// coast, stop, reverse, forward, regained, pull-in
	logic [5:0] cmd = '0;
	logic [9:0] volts = 10'h12C;
	logic [4:0] tw = '0, cw = '0;
	logic [3:0] alarm = '0;
	logic [2:0] mn = 3'h1;
	logic [6:0] pins, pins_q;
	logic [5:0] ctrl = '0;
	logic [4:0][4:0] sel = status_output_pkg::SEL_RESET;
	logic [31:0] wq[$];
	logic [6:0] pq[$];
	int num_errors = 0, total_checks = 0;
	always #5 clk_i = !clk_i;
	status_output_selector #(.POWERUP_CYCLES(PWR)) dut
	(
		.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .freq_output_active_i(freq),
		.dc_brake_active_i(brake), .dc_bus_volts_i(volts),
		.main_power_ok_i(m_ok), .control_power_ok_i(c_ok),
		.protect_active_i(prot), .restart_pullin_start_i(cmd[5]),
		.restart_freq_regained_i(cmd[4]), .thermal_warn_i(tw),
		.current_warn_i(cw), .fwd_cmd_i(cmd[3]), .rev_cmd_i(cmd[2]),
		.stop_cmd_i(cmd[1]), .coast_cmd_i(cmd[0]), .freq_arrival_flag_i(freq_arrival_flag),
		.freq_level_flag_i(fdt), .alarm_code_i(alarm), .fan_running_i(fan),
		.retry_active_i(retry), .overheat_warning_flag_i(oh),
		.motor_select_error_flag_i(err), .motor_changeover_flag_i(chg),
		.motor_number_i(mn), .relay_make_contact_o(pins[5]),
		.relay_break_contact_o(pins[6]), .status_output_1_o(pins[0]),
		.status_output_2_o(pins[1]), .status_output_3_o(pins[2]),
		.status_output_4_o(pins[3]), .status_output_5_o(pins[4])
	);
	host_terminal_reader host
	(
		.clk_i, .read_i(rd), .pins_i(pins), .pins_o(pins_q), .valid_o(pv)
	);
	////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// expected flag per selection code; unused codes stay low
	function automatic logic [31:0] flags();
		logic run;
		run = freq & !brake;
		return {4'h0, mn, mn == 3'h5, mn == 3'h4, mn == 3'h3, mn == 3'h2,
			mn == 3'h1, chg, err, oh, ctrl[5], retry, fan, alarm, echo,
			m_ok & c_ok & !prot & est, !run, ctrl[2:1] == 2'h0,
			mn != 3'h0 && mn < 3'h6 &&
			(ctrl[4] ? cw[mn - 3'h1] : tw[mn - 3'h1]), power_fail_restart_flag, volts < 10'h0C8,
			fdt, freq_arrival_flag, run};
	endfunction
	function automatic logic [6:0] pins_exp();
		logic [31:0] v;
		logic m;
		logic [4:0] o;
		v = flags();
		m = ctrl[0] ? !prot & est : prot;
		for (int k = 0; k < 5; k++)
			o[k] = v[sel[k]];
		return {!m, m, o};
	endfunction
	function automatic logic [31:0] status();
		logic [31:0] v;
		v = flags();
		return {16'h0, est, v[9], v[6], v[5], v[4], v[3], v[7], v[0], v[8],
			pins_exp()};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		wb_cyc_i <= '1;
		wb_stb_i <= '1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		// no cycle budget: only the watchdog ends a missing answer
		do
			@(posedge clk_i);
		while (wb_ack_o !== '1);
		wb_cyc_i <= '0;
		wb_stb_i <= '0;
		wb_we_i <= '0;
		tick(1);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		wq.push_back(e);
		wb('0, a, '0, 4'hF);
	endtask
	task automatic setc(input logic [5:0] c);
		ctrl = c;
		wb('1, 8'h00, {26'h0, c}, 4'h1);
	endtask
	task automatic look();
		pq.push_back(pins_exp());
		rd <= '1;
		tick(1);
		rd <= '0;
		tick(1);
	endtask
	task automatic pulse(input int b);
		cmd <= 6'(1 << b);
		tick(1);
		cmd <= '0;
		tick(2);
	endtask
	task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("ERROR bus word expected %h seen %h", e, g);
		end
	endtask
	task automatic cmp_pins(input logic [6:0] e, input logic [6:0] g);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("ERROR terminals expected %b seen %b", e, g);
		end
	endtask
	task automatic results();
		// expectations never answered count as mismatches
		num_errors += wq.size() + pq.size();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		if (wb_ack_o === '1 && !wb_we_i)
			cmp_word(wq.pop_front(), wb_dat_o);
		if (pv === '1)
			cmp_pins(pq.pop_front(), pins_q);
	end
	initial
	begin
		tick(20000);
		num_errors++;
		results();
	end
	////////////////////////////////////////
	initial
	begin
		tick(10);
		rst_i <= '0;
		tick(1);
		rd_reg(8'h00, '0);
		for (int k = 0; k < 5; k++)
			rd_reg(8'(4 * k + 4), {27'h0, sel[k]});
		rd_reg(8'h1C, '0);
		// lane 0 off: write must be dropped
		wb('1, 8'h00, 32'h3F, 4'hE);
		rd_reg(8'h00, '0);
		setc(6'h01);
		look();
		tick(PWR);
		est = '1;
		look();
		prot <= '1;
		tick(3);
		look();
		setc(6'h00);
		tick(2);
		look();
		prot <= '0;
		tick(3);
		look();
		for (int i = 0; i < 32; i++)
		begin
			for (int k = 0; k < 5; k++)
			begin
				sel[k] = 5'(i + 7 * k);
				wb('1, 8'(4 * k + 4), {27'h0, sel[k]}, 4'h1);
			end
			r = lfsr(lfsr(r));
			setc(r[5:0]);
			{freq, brake, m_ok, c_ok} <= {r[7:6], r[8] | r[9], r[10] | r[11]};
			prot <= r[12] & r[13];
			volts <= 10'h0C0 + 10'(r[17:14]);
			{tw, cw} <= r[27:18];
			r = lfsr(r);
			{freq_arrival_flag, fdt, fan, retry, oh, err, chg, alarm} <= r[10:0];
			// numbers 0, 6 and 7 select no motor
			mn <= r[13:11];
			tick(3);
			look();
			rd_reg(8'h18, status());
		end
		{prot, freq, brake} <= 3'h0;
		pulse(3);
		echo = '1;
		rd_reg(8'h18, status());
		freq <= '1;
		pulse(1);
		rd_reg(8'h18, status());
		freq <= '0;
		tick(3);
		echo = '0;
		rd_reg(8'h18, status());
		freq <= '1;
		pulse(2);
		pulse(0);
		rd_reg(8'h18, status());
		pulse(3);
		prot <= '1;
		tick(1);
		prot <= '0;
		tick(2);
		rd_reg(8'h18, status());
		setc(6'h00);
		pulse(5);
		power_fail_restart_flag = '1;
		rd_reg(8'h18, status());
		pulse(4);
		power_fail_restart_flag = '0;
		rd_reg(8'h18, status());
		setc(6'h08);
		pulse(5);
		rd_reg(8'h18, status());
		results();
	end
endmodule
`default_nettype wire
